// ===== print_pkt_pkg.sv
/*
 * Package for the serial print packetizer: register map, field layout,
 * reset values, mode encodings, timing counts and the stream carrier.
 * Assumes a 250 MHz core clock and a 32-bit classic Wishbone bus.
 */
package print_pkt_pkg;
	// Register byte offsets
	localparam logic [7:0] CTRL_OFS     = 8'h00;
	localparam logic [7:0] ROUTE_OFS    = 8'h04;
	localparam logic [7:0] STATUS_OFS   = 8'h08;
	// Control field positions
	localparam int         MODE_LSB     = 0;
	localparam int         DRV_LSB      = 2;
	localparam int         SHARE_BIT    = 4;
	localparam int         SIZE_LSB     = 8;
	localparam int         TLIM_LSB     = 16;
	// Reset values
	localparam logic [31:0] CTRL_RST    = 32'h0002_4000;
	localparam logic [31:0] ROUTE_RST   = 32'h0000_0000;
	// Special characters and timing
	localparam logic [7:0] CR_CHAR      = 8'h0D;
	localparam int         CLK_HZ       = 250_000_000;
	localparam int         TICK_MS      = 10;
	localparam int         TICK_CYC     = CLK_HZ / 1000 * TICK_MS;
	localparam int         MAX_PKT      = 64;

	typedef enum logic [1:0] {
		MODE_OFF   = 2'h0,
		MODE_PRINT = 2'h1,
		MODE_TRANS = 2'h3
	} port_mode_e;

	typedef enum logic [1:0] {
		POINT_TO_POINT_DRIVER = 2'h0,
		CTS_DRIVER_A          = 2'h1,
		HALF_DUPLEX_DRIVER    = 2'h2,
		TWO_WIRE_DRIVER       = 2'h3
	} drv_mode_e;

	// One byte of a print packet, with its closing mark
	typedef struct packed {
		logic       last;
		logic [7:0] data;
	} pkt_byte_s;
endpackage

// ===== serial_print_packetizer.sv
/*
 * Serial print packetizer: print-output path (network bytes to serial),
 * transparent/share path (serial bytes to network print packets) and
 * RS-485 driver/receiver enable control. Registers over classic Wishbone.
 * Assumes a byte-level serializer outside, synchronous inputs and one clock.
 */
// Chosen here: register access over Wishbone and the placing of the registers.
// Behaviour
// - Print mode sends routed print bytes out serially
// - Point-to-point keeps transmitter on, full duplex
// - Cts_driver_a driver enable follows CTS
// - Half duplex blanks receiver while transmitting
// - Two-wire follows CTS, blanks receiver transmitting
// - Share equals transparent except RTS
// - Transparent packs serial characters into packets
// - Packets go out with current target route
// - Route writable at run time or statically
// - Carriage return closes the packet
// - Exceeding size limit closes the packet
// - Inter-character gap over limit closes packet
// - Size one sends every character alone
`timescale 1ns/10ps
`default_nettype none
module serial_print_packetizer
	import print_pkt_pkg::*;
(
	input  wire logic        I_CORE_CLK,
	input  wire logic        I_RST,
	// Wishbone slave
	input  wire logic        I_WB_CYC,
	input  wire logic        I_WB_STB,
	input  wire logic        I_WB_WE,
	input  wire logic [7:0]  I_WB_ADR,
	input  wire logic [3:0]  I_WB_SEL,
	input  wire logic [31:0] I_WB_DAT,
	output logic      [31:0] O_WB_DAT,
	output logic             O_WB_ACK,
	// Route update from a network write message
	input  wire logic        I_NET_ROUTE_WR,
	input  wire logic [31:0] I_NET_ROUTE,
	// Print bytes from the router
	input  wire logic        I_NET_VALID,
	input  wire logic [7:0]  I_NET_DATA,
	output logic             O_NET_READY,
	// Serial transmit byte stream
	output logic             O_TX_VALID,
	output logic      [7:0]  O_TX_DATA,
	input  wire logic        I_TX_READY,
	input  wire logic        I_TX_BUSY,
	// Serial receive byte stream
	input  wire logic        I_RX_VALID,
	input  wire logic [7:0]  I_RX_DATA,
	// Packets towards the router
	output logic             O_PKT_VALID,
	output pkt_byte_s        O_PKT,
	output logic      [31:0] O_PKT_ROUTE,
	input  wire logic        I_PKT_READY,
	// RS-485 control and handshake
	input  wire logic        I_CTS,
	output logic             O_TX_OE,
	output logic             O_RX_EN,
	output logic             O_RTS
);
	logic [31:0] ctrl_r;
	logic [31:0] route_r;
	logic [31:0] rdat_r;
	logic        ack_r;
	logic [7:0]  tx_data_r;
	logic        tx_valid_r;
	pkt_byte_s   pkt_r;
	logic        pkt_valid_r;
	logic [31:0] pkt_route_r;
	logic [7:0]  count_r;
	logic [7:0]  count_nxt;
	logic [31:0] tick_r;
	logic [7:0]  hund_r;
	logic        drop_r;

	// Field decode
	wire port_mode_e mode     = port_mode_e'(ctrl_r[MODE_LSB +: 2]);
	wire drv_mode_e  drv      = drv_mode_e'(ctrl_r[DRV_LSB +: 2]);
	wire logic [7:0] size_lim = ctrl_r[SIZE_LSB +: 8];
	wire logic [7:0] time_lim = ctrl_r[TLIM_LSB +: 8];
	wire logic       is_print = (mode == MODE_PRINT);
	wire logic       is_trans = (mode == MODE_TRANS);

	// Bus decode
	wire logic req     = I_WB_CYC & I_WB_STB & ~ack_r;
	wire logic wr_ctrl = req & I_WB_WE & (I_WB_ADR == CTRL_OFS);
	wire logic wr_rte  = req & I_WB_WE & (I_WB_ADR == ROUTE_OFS);
	wire logic [31:0] be_mask = {{8{I_WB_SEL[3]}}, {8{I_WB_SEL[2]}},
	                             {8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};
	wire logic [31:0] status = {22'h0, drop_r, pkt_valid_r, count_r};
	wire logic [31:0] rd_mux = (I_WB_ADR == CTRL_OFS)   ? ctrl_r  :
	                           (I_WB_ADR == ROUTE_OFS)  ? route_r :
	                           (I_WB_ADR == STATUS_OFS) ? status  : 32'h0;

	// One-wait-state answer; unmapped reads return zero, writes dropped
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			ack_r  <= 1'b0;
			rdat_r <= 32'h0;
		end else begin
			ack_r  <= req;
			rdat_r <= rd_mux;
		end
	end

	// Control register with byte enables
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST)
			ctrl_r <= CTRL_RST;
		else if (wr_ctrl)
			ctrl_r <= (ctrl_r & ~be_mask) | (I_WB_DAT & be_mask);
	end

	// Target route: network write wins over static software write
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST)
			route_r <= ROUTE_RST;
		else if (I_NET_ROUTE_WR)
			route_r <= I_NET_ROUTE;
		else if (wr_rte)
			route_r <= (route_r & ~be_mask) | (I_WB_DAT & be_mask);
	end

	// Print path: one byte register between router and serializer
	wire logic tx_take = is_print & I_NET_VALID & (~tx_valid_r | I_TX_READY);
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			tx_valid_r <= 1'b0;
			tx_data_r  <= 8'h00;
		end else if (tx_take) begin
			tx_valid_r <= 1'b1;
			tx_data_r  <= I_NET_DATA;
		end else if (I_TX_READY)
			tx_valid_r <= 1'b0;
	end

	// Transparent path closing conditions
	wire logic out_free = ~pkt_valid_r | I_PKT_READY;
	wire logic rx_take  = is_trans & I_RX_VALID & O_RX_EN;
	// Only accepted bytes count; a refused byte must not grow the packet
	wire logic rx_acc   = rx_take & out_free;
	wire logic is_cr    = (I_RX_DATA == CR_CHAR);
	// Size limit is exceeded once the count reaches it; size one closes each byte
	wire logic size_hit = (size_lim != 8'h00) & ((count_r + 8'h01) >= size_lim);
	wire logic tick     = (tick_r == (TICK_CYC - 1));
	wire logic gap_hit  = (count_r != 8'h00) & (hund_r >= time_lim) & out_free;
	wire logic close_rx = rx_acc & (is_cr | size_hit);

	assign count_nxt = close_rx ? 8'h00 :
	                   rx_acc   ? count_r + 8'h01 :
	                   gap_hit  ? 8'h00 : count_r;

	// Packet byte out; a character refused by a stalled router is counted lost
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			pkt_valid_r <= 1'b0;
			pkt_r       <= '0;
			pkt_route_r <= 32'h0;
			count_r     <= 8'h00;
			drop_r      <= 1'b0;
		end else begin
			count_r <= count_nxt;
			if (rx_take & ~out_free)
				drop_r <= 1'b1;
			if (rx_acc) begin
				pkt_valid_r <= 1'b1;
				pkt_r       <= '{last: close_rx, data: I_RX_DATA};
				pkt_route_r <= route_r;
			end else if (gap_hit) begin
				// Zero-length closing mark ends a packet on timeout
				pkt_valid_r <= 1'b1;
				pkt_r       <= '{last: 1'b1, data: 8'h00};
			end else if (I_PKT_READY)
				pkt_valid_r <= 1'b0;
		end
	end

	// Hundredths timer, idle while empty, restarted per character
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST | rx_take | (count_r == 8'h00)) begin
			tick_r <= 32'h0;
			hund_r <= 8'h00;
		end else if (tick) begin
			tick_r <= 32'h0;
			if (hund_r != 8'hFF)
				hund_r <= hund_r + 8'h01;
		end else
			tick_r <= tick_r + 32'h1;
	end

	// Driver and receiver enables per driver mode
	wire logic sending = tx_valid_r | I_TX_BUSY;
	always_comb begin
		O_TX_OE = 1'b1;
		O_RX_EN = 1'b1;
		unique case (drv)
			POINT_TO_POINT_DRIVER: O_TX_OE = 1'b1;
			CTS_DRIVER_A:          O_TX_OE = I_CTS;
			HALF_DUPLEX_DRIVER:    O_RX_EN = ~sending;
			TWO_WIRE_DRIVER: begin
				O_TX_OE = I_CTS;
				O_RX_EN = ~sending;
			end
		endcase
	end

	// Share mode differs only in RTS: asserted while sending
	assign O_RTS       = is_trans & ctrl_r[SHARE_BIT] ? sending : is_trans;
	assign O_NET_READY = is_print & (~tx_valid_r | I_TX_READY);
	assign O_TX_VALID  = tx_valid_r;
	assign O_TX_DATA   = tx_data_r;
	assign O_PKT_VALID = pkt_valid_r;
	assign O_PKT       = pkt_r;
	assign O_PKT_ROUTE = pkt_route_r;
	assign O_WB_ACK    = ack_r;
	assign O_WB_DAT    = rdat_r;

	// Checks
	cr_closes_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		rx_take & is_cr & out_free |=> pkt_valid_r & pkt_r.last & (count_r == 8'h00))
		else $error("return did not close packet");
	size_one_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		rx_take & out_free & (size_lim == 8'h01) |=> pkt_r.last)
		else $error("size one byte not closed");
	size_lim_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		(size_lim != 8'h00) |-> count_r < size_lim)
		else $error("packet grew past limit");
	cts_follow_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		drv == CTS_DRIVER_A |-> O_TX_OE == I_CTS)
		else $error("cts_driver_a enable not following cts");
	ptp_duplex_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		drv == POINT_TO_POINT_DRIVER |-> O_TX_OE & O_RX_EN)
		else $error("point to point not full duplex");
	half_echo_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		drv == HALF_DUPLEX_DRIVER & sending |-> O_TX_OE & ~O_RX_EN)
		else $error("half duplex receiver open");
	two_wire_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		drv == TWO_WIRE_DRIVER |-> (O_TX_OE == I_CTS) & (O_RX_EN == ~sending))
		else $error("two wire enables wrong");
	route_upd_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		I_NET_ROUTE_WR |=> route_r == $past(I_NET_ROUTE))
		else $error("route not updated");
	idle_timer_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		count_r == 8'h00 |=> hund_r == 8'h00)
		else $error("timer ran while empty");
	print_out_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		tx_take |=> O_TX_VALID & (O_TX_DATA == $past(I_NET_DATA)))
		else $error("print byte not forwarded");

	// Packet assembly checks
	gap_close_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		gap_hit & ~rx_take |=> pkt_valid_r & pkt_r.last & (count_r == 8'h00))
		else $error("gap did not close packet");
	size_close_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		rx_acc & size_hit |=> pkt_r.last & (count_r == 8'h00))
		else $error("size limit did not close packet");
	new_pkt_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		close_rx |=> (count_r == 8'h00) & pkt_r.last & (pkt_r.data == $past(I_RX_DATA)))
		else $error("closing byte not kept last");
	rx_data_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		rx_acc |=> pkt_valid_r & (pkt_r.data == $past(I_RX_DATA)))
		else $error("received byte not packed");
	route_out_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		rx_acc |=> pkt_route_r == $past(route_r))
		else $error("packet route not current");
	pkt_hold_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		pkt_valid_r & ~I_PKT_READY |=> pkt_valid_r & $stable(pkt_r))
		else $error("stalled packet byte changed");
	lost_byte_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		rx_take & ~out_free |=> drop_r & (count_r == $past(count_r)))
		else $error("lost byte not flagged");
	timer_restart_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		rx_take |=> (hund_r == 8'h00) & (tick_r == 32'h0))
		else $error("timer not restarted");
	hund_step_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		tick & ~rx_take & (count_r != 8'h00) & (hund_r != 8'hFF)
		|=> hund_r == $past(hund_r) + 8'h01)
		else $error("hundredths count missed");

	// Driver and RTS checks
	half_tx_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		drv == HALF_DUPLEX_DRIVER |-> O_TX_OE & (O_RX_EN == ~sending))
		else $error("half duplex enables wrong");
	share_rts_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		is_trans & ctrl_r[SHARE_BIT] |-> O_RTS == sending)
		else $error("share rts not following send");
	trans_rts_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		is_trans & ~ctrl_r[SHARE_BIT] |-> O_RTS)
		else $error("transparent rts low");

	// Print path checks
	print_hold_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		tx_valid_r & ~I_TX_READY |=> tx_valid_r & $stable(tx_data_r))
		else $error("print byte not held");
	print_only_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
		~is_print |-> ~O_NET_READY)
		else $error("print bytes taken outside print mode");
endmodule
`default_nettype wire

// ===== serial_peer_model.sv
/*
 * Serial peripheral seen at the byte level: takes transmit bytes, reports
 * busy, drives CTS. Assumes the bench commands busy and CTS levels.
 */
`timescale 1ns/10ps
`default_nettype none
module serial_peer_model (
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_tx_valid,
	input  wire logic [7:0] i_tx_data,
	input  wire logic       i_busy_req,
	input  wire logic       i_cts_req,
	output logic            o_tx_ready,
	output logic            o_tx_busy,
	output logic            o_cts,
	output logic      [7:0] o_last
);
	// Stalls while busy, so a slow peripheral is modelled as well
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_tx_ready <= 1'b1;
			o_tx_busy  <= 1'b0;
			o_cts      <= 1'b0;
			o_last     <= 8'h00;
		end else begin
			o_tx_ready <= !i_busy_req;
			o_tx_busy  <= i_busy_req;
			o_cts      <= i_cts_req;
			if (i_tx_valid && o_tx_ready) begin
				o_last <= i_tx_data; // Same byte format both ends
			end
		end
	end
endmodule
`default_nettype wire

// ===== serial_print_packetizer_tb.sv
/*
 * Self-checking bench for the serial print packetizer.
 * Assumes the package constants and the peer model beside it.
 */
`timescale 1ns/10ps
`default_nettype none
module serial_print_packetizer_tb;
	import print_pkt_pkg::*;
	logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, rwr = 0, nv = 0, rxv = 0;
	logic busy_req = 0, cts_req = 0, prdy = 1;
	logic [7:0] adr = 0, nd = 0, rxd = 0;
	logic [31:0] wd = 0, rd, nroute = 0;
	wire logic [31:0] wbd, proute;
	wire logic ack, nrdy, txv, txr, txb, pv, cts, oe, rxen, rts;
	wire logic [7:0] txd, last;
	wire pkt_byte_s pkt;
	int err_count = 0, total_checks = 0, cyc_n = 0;

	initial forever #2 clk = ~clk;

	serial_print_packetizer serial_print_packetizer_inst (.I_CORE_CLK(clk), .I_RST(rst),
		.I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hF),
		.I_WB_DAT(wd), .O_WB_DAT(wbd), .O_WB_ACK(ack), .I_NET_ROUTE_WR(rwr),
		.I_NET_ROUTE(nroute), .I_NET_VALID(nv), .I_NET_DATA(nd), .O_NET_READY(nrdy),
		.O_TX_VALID(txv), .O_TX_DATA(txd), .I_TX_READY(txr), .I_TX_BUSY(txb),
		.I_RX_VALID(rxv), .I_RX_DATA(rxd), .O_PKT_VALID(pv), .O_PKT(pkt),
		.O_PKT_ROUTE(proute), .I_PKT_READY(prdy), .I_CTS(cts), .O_TX_OE(oe),
		.O_RX_EN(rxen), .O_RTS(rts));
	serial_peer_model serial_peer_model_inst (.i_clk(clk), .i_rst(rst), .i_tx_valid(txv),
		.i_tx_data(txd), .i_busy_req(busy_req), .i_cts_req(cts_req), .o_tx_ready(txr),
		.o_tx_busy(txb), .o_cts(cts), .o_last(last));

	task summarize;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s exp %h seen %h", what, exp, seen);
		end
	endtask
	// One classic cycle; ack sampled on rising edges, released at that edge
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wd <= d;
		do @(posedge clk); while (ack !== 1'b1);
		rd = wbd;
		cyc <= 0;
		stb <= 0;
		we <= 0;
	endtask
	task rx(input logic [7:0] b, input logic l, input logic [31:0] r);
		@(posedge clk); rxv <= 1; rxd <= b;
		@(posedge clk); rxv <= 0;
		#1;
		chk(pv, 1, "pkt_valid");
		chk(pkt, {l, b}, "pkt");
		chk(proute, r, "pkt_route");
	endtask
	task t_regs;
		chk(nrdy, 0, "net_ready_off");
		wb(0, CTRL_OFS, 0); chk(rd, CTRL_RST, "ctrl");
		wb(0, ROUTE_OFS, 0); chk(rd, ROUTE_RST, "route");
		wb(1, 8'h0C, 32'hFFFF_FFFF); wb(0, 8'h0C, 0); chk(rd, 0, "unmapped");
	endtask
	// Every driver mode against every CTS and busy level
	task t_drv;
		for (int i = 0; i < 16; i++) begin
			if (i[1:0] == 2'h0) wb(1, CTRL_OFS, CTRL_RST | (i[3:2] << DRV_LSB));
			@(posedge clk); cts_req <= i[1]; busy_req <= i[0];
			repeat (3) @(posedge clk);
			chk(oe, i[2] ? i[1] : 1'b1, "tx_oe");
			chk(rxen, i[3] ? !i[0] : 1'b1, "rx_en");
		end
		@(posedge clk); busy_req <= 0;
	endtask
	task t_print;
		wb(1, CTRL_OFS, CTRL_RST | MODE_PRINT);
		@(posedge clk);
		busy_req <= 1;
		nv <= 1;
		nd <= 8'h5A;
		do @(posedge clk); while (nrdy !== 1'b1);
		nv <= 0;
		repeat (3) @(posedge clk);
		chk(txv, 1, "tx_held");
		chk(txd, 8'h5A, "tx_data");
		busy_req <= 0;
		repeat (4) @(posedge clk);
		chk(last, 8'h5A, "serial_byte");
	endtask
	// Route holds the drops reversed for the return leg
	task t_trans(input logic sh);
		wb(1, ROUTE_OFS, 32'h0091_34A6);
		wb(1, CTRL_OFS, CTRL_RST | MODE_TRANS | (sh << SHARE_BIT)); // time limit 2
		chk(rts, !sh, "rts_idle");
		@(posedge clk);
		busy_req <= 1;
		repeat (2) @(posedge clk);
		chk(rts, 1, "rts_sending");
		busy_req <= 0;
		repeat (2) @(posedge clk);
		rx(8'h41, 0, 32'h0091_34A6);
		rx(CR_CHAR, 1, 32'h0091_34A6);
		rx(8'h42, 0, 32'h0091_34A6);
		rx(CR_CHAR, 1, 32'h0091_34A6);
	endtask
	task t_size;
		wb(1, CTRL_OFS, (CTRL_RST & ~32'h0000_FF00) | (1 << SIZE_LSB) | MODE_TRANS);
		rx(8'h61, 1, 32'h0091_34A6);
		rx(8'h62, 1, 32'h0091_34A6);
		wb(1, CTRL_OFS, (CTRL_RST & ~32'h0000_FF00) | (2 << SIZE_LSB) | MODE_TRANS);
		rx(8'h63, 0, 32'h0091_34A6);
		rx(8'h64, 1, 32'h0091_34A6);
	endtask
	task t_netroute;
		@(posedge clk); rwr <= 1; nroute <= 32'h0042_2107;
		@(posedge clk); rwr <= 0;
		rx(8'h65, 0, 32'h0042_2107);
		wb(0, ROUTE_OFS, 0); chk(rd, 32'h0042_2107, "route_rd");
		wb(0, STATUS_OFS, 0);
		chk(rd, 32'h0000_0001, "status_count");
	endtask
	// Router stalls: held byte stays, a second byte is lost and flagged
	task t_stall;
		@(posedge clk);
		prdy <= 0;
		rx(8'h66, 1, 32'h0042_2107);
		@(posedge clk);
		rxv <= 1;
		rxd <= 8'h67;
		@(posedge clk);
		rxv <= 0;
		@(posedge clk);
		chk(pkt, {1'b1, 8'h66}, "pkt_held");
		prdy <= 1;
		wb(0, STATUS_OFS, 0);
		chk(rd, 32'h0000_0200, "status_drop");
	endtask

	// Hang guard, far above the roughly 180 cycles needed
	always @(posedge clk) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			err_count++;
			summarize();
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 0;
		t_regs; t_drv; t_print; t_trans(0); t_trans(1); t_size; t_netroute; t_stall;
		summarize();
	end
endmodule
`default_nettype wire
